/* File: shared/bch_pkg.sv */
package bch_pkg;
	// controller role sequencer states
	typedef enum logic [1:0] {
		BCH_IDLE = 2'b00,
		BCH_ACTIVE = 2'b01,
		BCH_PASS_ADDR = 2'b10,
		BCH_PASS_TCT = 2'b11
	} bch_state_e;

	// bus addresses and the fixed-point address parameter
	localparam int ADDR_W = 5;
	localparam int PARAM_W = 16;
	localparam int PARAM_FRAC = 4;
	localparam logic [PARAM_W-1:0] PARAM_HALF = 16'h0008;
	localparam logic [PARAM_W-1:0] ADDR_MAX = 16'h001E;
	localparam logic [ADDR_W-1:0] DEFAULT_RET_ADDR = 5'h00;
	localparam logic [ADDR_W-1:0] RST_SEC_ADDR = 5'h00;

	// request-control flag position in the standard event status register
	localparam int ESR_REQ_CTRL_BIT = 1;

	// idle hold limit before control goes back on its own
	localparam longint unsigned HOLD_TMO_S = 10;
	localparam longint unsigned CLK_HZ = 200_000_000;
	localparam longint unsigned HOLD_TMO_CYC = HOLD_TMO_S * CLK_HZ;
	localparam int TMR_W = 32;
endpackage

/* File: design/bch_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module bch_ctrl
	import bch_pkg::*;
#(
	parameter int unsigned HOLD_TMO = 32'(HOLD_TMO_CYC)
)(
	input wire logic clock,
	input wire logic srst,
	input wire logic ifc_pin,
	input wire logic talker_addressed,
	input wire logic tct_rx,
	input wire logic ret_cmd_stb,
	input wire logic [PARAM_W-1:0] ret_cmd_prim,
	input wire logic ret_cmd_two,
	input wire logic [PARAM_W-1:0] ret_cmd_sec,
	input wire logic prog_running,
	input wire logic prog_pass,
	input wire logic prog_stop,
	input wire logic prog_req_ctrl,
	input wire logic esr_clear,
	input wire logic ctrl_op_busy,
	input wire logic ctrl_op_done,
	output logic active_ctrl_q,
	output logic atn_en_q,
	output logic talk_addr_stb_q,
	output logic tct_send_stb_q,
	output logic [ADDR_W-1:0] ret_prim_q,
	output logic [ADDR_W-1:0] ret_sec_q,
	output logic ret_sec_vld_q,
	output logic ret_cmd_err_q,
	output logic esr_req_ctrl_q
);
	bch_state_e state_q, state_d;
	logic ifc_s1_q, ifc_s2_q, ifc_s3_q, ifc_lvl_q;
	logic [TMR_W-1:0] tmr_q;
	logic ret_seen_q;
	logic give_back;
	logic [PARAM_W-1:0] prim_rnd, sec_rnd;
	logic prim_ok, sec_ok;

	// round a fixed-point parameter to the nearest whole address
	function automatic logic [PARAM_W-1:0] round_param(input logic [PARAM_W-1:0] v);
		logic [PARAM_W:0] s;
		s = {1'b0, v} + {1'b0, PARAM_HALF};
		return PARAM_W'(s >> PARAM_FRAC);
	endfunction

	// interface clear pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			ifc_s1_q <= 1'b0;
			ifc_s2_q <= 1'b0;
			ifc_s3_q <= 1'b0;
			ifc_lvl_q <= 1'b0;
		end
		else
		begin
			ifc_s1_q <= ifc_pin;
			ifc_s2_q <= ifc_s1_q;
			ifc_s3_q <= ifc_s2_q;
			if (ifc_s2_q == ifc_s3_q)
				ifc_lvl_q <= ifc_s3_q;
		end
	end

	// return address decode; out-of-range values are refused whole
	always_comb
	begin
		prim_rnd = round_param(ret_cmd_prim);
		sec_rnd = round_param(ret_cmd_sec);
		prim_ok = (prim_rnd <= ADDR_MAX);
		sec_ok = !ret_cmd_two || (sec_rnd <= ADDR_MAX);
	end

	// reasons to give control back while holding it
	always_comb
	begin
		give_back = prog_pass
			|| prog_stop
			|| (!prog_running && ctrl_op_done)
			|| (!prog_running && !ctrl_op_busy && tmr_q >= HOLD_TMO - 1);
	end

	// role sequencer; interface clear beats everything, no message is sent then
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			BCH_IDLE:
				if (talker_addressed && tct_rx)
					state_d = BCH_ACTIVE;
			BCH_ACTIVE:
				if (give_back)
					state_d = BCH_PASS_ADDR;
			BCH_PASS_ADDR:
				state_d = BCH_PASS_TCT;
			BCH_PASS_TCT:
				state_d = BCH_IDLE;
			default:
				state_d = BCH_IDLE;
		endcase
		if (ifc_lvl_q)
			state_d = BCH_IDLE;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			state_q <= BCH_IDLE;
		else
			state_q <= state_d;
	end

	// role outputs; attention only while this end holds control
	// attention must still stand in the take-control cycle, since that message needs it
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			active_ctrl_q <= 1'b0;
			atn_en_q <= 1'b0;
		end
		else
		begin
			active_ctrl_q <= (state_d != BCH_IDLE) || (state_q == BCH_PASS_TCT && !ifc_lvl_q);
			atn_en_q <= (state_d != BCH_IDLE) || (state_q == BCH_PASS_TCT && !ifc_lvl_q);
		end
	end

	// handover strobes: talk address goes out one cycle ahead of take-control
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			talk_addr_stb_q <= 1'b0;
			tct_send_stb_q <= 1'b0;
		end
		else
		begin
			talk_addr_stb_q <= (state_q == BCH_PASS_ADDR) && !ifc_lvl_q;
			tct_send_stb_q <= (state_q == BCH_PASS_TCT) && !ifc_lvl_q;
		end
	end

	// hold timer restarts on each take-over and while a controller operation runs
	always_ff @(posedge clock)
	begin
		if (srst || state_q != BCH_ACTIVE || ctrl_op_busy || prog_running)
			tmr_q <= '0;
		else if (tmr_q < HOLD_TMO - 1)
			tmr_q <= tmr_q + 1'b1;
	end

	// stored return address; default 0 until a valid command arrives
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			ret_prim_q <= DEFAULT_RET_ADDR;
			ret_sec_q <= RST_SEC_ADDR;
			ret_sec_vld_q <= 1'b0;
			ret_seen_q <= 1'b0;
			ret_cmd_err_q <= 1'b0;
		end
		else
		begin
			ret_cmd_err_q <= ret_cmd_stb && !(prim_ok && sec_ok);
			if (ret_cmd_stb && prim_ok && sec_ok)
			begin
				ret_prim_q <= prim_rnd[ADDR_W-1:0];
				ret_sec_q <= ret_cmd_two ? sec_rnd[ADDR_W-1:0] : RST_SEC_ADDR;
				ret_sec_vld_q <= ret_cmd_two;
				ret_seen_q <= 1'b1;
			end
		end
	end

	// request-control flag; a request in the clearing cycle still lands
	always_ff @(posedge clock)
	begin
		if (srst)
			esr_req_ctrl_q <= 1'b0;
		else if (prog_req_ctrl)
			esr_req_ctrl_q <= 1'b1;
		else if (esr_clear)
			esr_req_ctrl_q <= 1'b0;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	a_take_control: assert property (
		state_q == BCH_IDLE && talker_addressed && tct_rx && !ifc_lvl_q |=> active_ctrl_q)
		else $error("control not taken on take-control");
	a_ret_range: assert property (
		ret_cmd_stb && prim_ok && sec_ok |=> ret_prim_q == $past(prim_rnd[ADDR_W-1:0]))
		else $error("valid return address not stored");
	a_ret_reject: assert property (
		ret_cmd_stb && prim_rnd > ADDR_MAX |=> $stable(ret_prim_q) && ret_cmd_err_q)
		else $error("out of range return address accepted");
	a_sec_store: assert property (
		ret_cmd_stb && ret_cmd_two && prim_ok && sec_ok |=> ret_sec_vld_q
			&& ret_sec_q == $past(sec_rnd[ADDR_W-1:0]))
		else $error("secondary address not stored");
	a_pass_prog: assert property (
		state_q == BCH_ACTIVE && prog_pass && !ifc_lvl_q |=> state_q == BCH_PASS_ADDR)
		else $error("program pass-control ignored");
	a_req_flag: assert property (
		prog_req_ctrl |=> esr_req_ctrl_q)
		else $error("request-control flag not set");
	a_print_back: assert property (
		state_q == BCH_ACTIVE && !prog_running && ctrl_op_done && !ifc_lvl_q
			|=> state_q == BCH_PASS_ADDR)
		else $error("no return after print");
	a_default_addr: assert property (
		tct_send_stb_q && !ret_seen_q |-> ret_prim_q == DEFAULT_RET_ADDR)
		else $error("default return address not zero");
	a_ifc_drop: assert property (
		ifc_lvl_q |=> !active_ctrl_q && !atn_en_q)
		else $error("control kept under interface clear");
	a_hold_limit: assert property (
		state_q == BCH_ACTIVE && !prog_running && !ctrl_op_busy && !ifc_lvl_q
			&& tmr_q == HOLD_TMO - 1 |=> state_q == BCH_PASS_ADDR)
		else $error("idle hold limit missed");
	a_talk_first: assert property (
		tct_send_stb_q |-> $past(talk_addr_stb_q))
		else $error("take-control without talk address");
	a_atn_idle: assert property (
		state_q == BCH_IDLE && $past(state_q) == BCH_IDLE |-> !atn_en_q && !talk_addr_stb_q)
		else $error("attention driven while not active");
endmodule

`default_nettype wire

/* File: test/bch_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module bch_peer
	import bch_pkg::*;
(
	input wire logic clock,
	output logic talker_addressed,
	output logic tct_rx,
	output logic ret_cmd_stb,
	output logic [PARAM_W-1:0] ret_cmd_prim,
	output logic ret_cmd_two,
	output logic [PARAM_W-1:0] ret_cmd_sec
);
	// quiet bus until a handover is commanded
	initial
	begin
		talker_addressed = 1'b0;
		tct_rx = 1'b0;
		ret_cmd_stb = 1'b0;
		ret_cmd_prim = 16'h0000;
		ret_cmd_two = 1'b0;
		ret_cmd_sec = 16'h0000;
	end
	// return address, then talk address, then take-control
	task automatic give(input logic [15:0] p, input logic two, input logic [15:0] s,
		input logic tal);
	begin
		@(posedge clock);
		ret_cmd_stb <= 1'b1;
		ret_cmd_prim <= p;
		ret_cmd_two <= two;
		ret_cmd_sec <= s;
		@(posedge clock);
		ret_cmd_stb <= 1'b0;
		ret_cmd_prim <= ~p; // stale data must not be taken
		ret_cmd_sec <= ~s;
		talker_addressed <= tal;
		@(posedge clock);
		tct_rx <= 1'b1;
		@(posedge clock);
		tct_rx <= 1'b0;
		talker_addressed <= 1'b0;
	end
	endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock, srst, ifc_pin, prog_running, prog_pass, prog_stop, prog_req_ctrl;
	logic esr_clear, ctrl_op_busy, ctrl_op_done, talker_addressed, tct_rx, ret_cmd_stb;
	logic ret_cmd_two, active_ctrl_q, atn_en_q, talk_addr_stb_q, tct_send_stb_q;
	logic ret_sec_vld_q, ret_cmd_err_q, esr_req_ctrl_q;
	logic [15:0] ret_cmd_prim, ret_cmd_sec;
	logic [4:0] ret_prim_q, ret_sec_q;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	int err_cnt = 0;
	bch_peer i_bch_peer (.clock, .talker_addressed, .tct_rx, .ret_cmd_stb, .ret_cmd_prim,
		.ret_cmd_two, .ret_cmd_sec);
	// short hold limit keeps the idle timeout test brief
	bch_ctrl #(.HOLD_TMO(20)) i_bch_ctrl (.clock, .srst, .ifc_pin, .talker_addressed,
		.tct_rx, .ret_cmd_stb, .ret_cmd_prim, .ret_cmd_two, .ret_cmd_sec, .prog_running,
		.prog_pass, .prog_stop, .prog_req_ctrl, .esr_clear, .ctrl_op_busy, .ctrl_op_done,
		.active_ctrl_q, .atn_en_q, .talk_addr_stb_q, .tct_send_stb_q, .ret_prim_q,
		.ret_sec_q, .ret_sec_vld_q, .ret_cmd_err_q, .esr_req_ctrl_q);
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (ret_cmd_err_q === 1'b1)
			err_cnt++;
		if (cyc == 3000)
		begin
			fails++;
			summarize();
		end
	end
	task automatic chk(input logic got, input logic exp);
	begin
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task automatic tick(input int n);
	begin
		repeat (n) @(posedge clock);
		#1;
	end
	endtask
	// talk strobe within n cycles, take-control next, then role drops
	task automatic hand(input int n);
		int i;
	begin
		i = 0;
		while (i < n && talk_addr_stb_q !== 1'b1)
		begin
			tick(1);
			i++;
		end
		chk(talk_addr_stb_q, 1'b1);
		tick(1);
		chk(tct_send_stb_q, 1'b1);
		chk(active_ctrl_q, 1'b1);
		tick(1);
		chk(active_ctrl_q, 1'b0);
		chk(atn_en_q, 1'b0);
	end
	endtask
	// out-of-range address refused, default target used, program pass
	task automatic t_default;
	begin
		i_bch_peer.give(16'h01E8, 1'b0, 16'h0000, 1'b1);
		tick(1);
		chk(active_ctrl_q, 1'b1);
		chk(atn_en_q, 1'b1);
		chk(ret_prim_q === 5'h00, 1'b1);
		chk(err_cnt == 1, 1'b1);
		prog_running <= 1'b1;
		@(posedge clock);
		prog_pass <= 1'b1;
		@(posedge clock);
		prog_pass <= 1'b0;
		hand(4);
		$display("test default done");
	end
	endtask
	// two numbers with rounding, stop hands back
	task automatic t_two;
	begin
		i_bch_peer.give(16'h0150, 1'b1, 16'h0048, 1'b1);
		tick(1);
		chk(ret_prim_q === 5'h15, 1'b1);
		chk(ret_sec_q === 5'h05, 1'b1);
		chk(ret_sec_vld_q, 1'b1);
		@(posedge clock);
		prog_stop <= 1'b1;
		@(posedge clock);
		prog_stop <= 1'b0;
		hand(4);
		prog_running <= 1'b0;
		$display("test two done");
	end
	endtask
	// take-control without talk address is ignored
	task automatic t_refuse;
	begin
		i_bch_peer.give(16'h01E0, 1'b0, 16'h0000, 1'b0);
		tick(2);
		chk(active_ctrl_q, 1'b0);
		chk(atn_en_q, 1'b0);
		chk(ret_prim_q === 5'h1E, 1'b1);
		chk(err_cnt == 1, 1'b1);
		chk(ret_sec_vld_q, 1'b0);
		chk(ret_sec_q === 5'h00, 1'b1);
		$display("test refuse done");
	end
	endtask
	// idle hold timeout, then print completion
	task automatic t_idle;
	begin
		i_bch_peer.give(16'h0010, 1'b0, 16'h0000, 1'b1);
		tick(15);
		chk(active_ctrl_q, 1'b1);
		hand(30);
		i_bch_peer.give(16'h0010, 1'b0, 16'h0000, 1'b1);
		ctrl_op_busy <= 1'b1;
		tick(40);
		chk(active_ctrl_q, 1'b1);
		ctrl_op_done <= 1'b1;
		ctrl_op_busy <= 1'b0;
		@(posedge clock);
		ctrl_op_done <= 1'b0;
		hand(4);
		$display("test idle done");
	end
	endtask
	// request flag and interface clear
	task automatic t_misc;
	begin
		// request and clear in one cycle: the request wins, clear alone then drops it
		@(posedge clock);
		prog_req_ctrl <= 1'b1;
		esr_clear <= 1'b1;
		@(posedge clock);
		prog_req_ctrl <= 1'b0;
		tick(0);
		chk(esr_req_ctrl_q, 1'b1);
		chk(|({6'h00, esr_req_ctrl_q, 1'b0} & 8'h02), 1'b1);
		tick(1);
		chk(esr_req_ctrl_q, 1'b0);
		esr_clear <= 1'b0;
		i_bch_peer.give(16'h0010, 1'b0, 16'h0000, 1'b1);
		ifc_pin <= 1'b1;
		tick(7);
		chk(active_ctrl_q, 1'b0);
		chk(talk_addr_stb_q, 1'b0);
		ifc_pin <= 1'b0;
		tick(5);
		$display("test misc done");
	end
	endtask
	task automatic summarize;
	begin
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	initial
	begin
		{srst, ifc_pin, prog_running, prog_pass, prog_stop} = 5'h1_0;
		{prog_req_ctrl, esr_clear, ctrl_op_busy, ctrl_op_done} = 4'h0;
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		tick(2);
		t_default();
		t_two();
		t_refuse();
		t_idle();
		t_misc();
		summarize();
	end
endmodule
`default_nettype wire
